/* design/bti_bit_flip.sv */
// bti_bit_flip: process stage, inverts one bit of the byte read back.
// assumes: rdata is valid on the clock edge where load is high.
`timescale 1ns/1ps
`include "bti_map.svh"
`default_nettype none

module bti_bit_flip
  import bti_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   load,
  input  wire logic [2:0]             bit_sel,
  input  wire logic [`BTI_DATA_W-1:0] rdata,
  output var  logic [`BTI_DATA_W-1:0] wdata
);

  ////////////////////////////////////////////////////////////////////////
  // only the chosen bit moves, the other seven pass through untouched

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wdata <= `BTI_DATA_RST;
    end
    else if (ce && load)
    begin
      wdata <= rdata ^ bti_bit_mask(bit_sel);
    end
  end

endmodule

`default_nettype wire

/* design/bti_exec.sv */
// bti_exec: executes the single-word bit-invert instruction as a
// read-modify-write of one data-memory byte over four quarter phases.
// assumes: instruction word and bank select come from core logic on clk;
// data memory answers a read one clock after mem_rd_en is seen.
`timescale 1ns/1ps
`include "bti_map.svh"
`default_nettype none

// Functional notes
// - match top nibble 0111; then 3-bit bit number, bank flag, 8-bit file address.
// - invert selected bit of addressed byte, other seven bits unchanged.
// - bank flag 0 maps file address into fixed access bank, ignoring bank select.
// - bank flag 1 forms address from bank select register and file address.
// - no arithmetic status flag is changed by this instruction.
module bti_exec
  import bti_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   instr_valid,
  input  wire logic [`BTI_WORD_W-1:0] instr_word,
  input  wire logic [`BTI_BANK_W-1:0] bank_select_reg,
  input  wire logic [`BTI_DATA_W-1:0] mem_rdata,
  output var  bti_phase_t             q_phase,
  output logic                        instr_taken,
  output var  logic                   exec_busy,
  output var  logic [`BTI_ADDR_W-1:0] mem_addr,
  output var  logic                   mem_rd_en,
  output var  logic                   mem_wr_en,
  output var  logic [`BTI_DATA_W-1:0] mem_wdata,
  output var  logic                   exec_done,
  output var  logic                   status_wr_en
);

  ////////////////////////////////////////////////////////////////////////
  // helper functions

  // opcode match on the top nibble
  function automatic logic bti_is_invert(input logic [`BTI_WORD_W-1:0] w);
    return w[`BTI_OPC_HI:`BTI_OPC_LO] == `BTI_OPCODE;
  endfunction

  // full data-memory address from bank flag, bank select and file address
  function automatic bti_addr_t bti_form_addr
  (
    input logic                   bank_flag,
    input logic [`BTI_BANK_W-1:0] bsel,
    input logic [`BTI_DATA_W-1:0] f
  );
    bti_addr_t a;
    if (bank_flag)
    begin
      a = {bsel, f};
    end
    else if (f < `BTI_ACCESS_SPLIT)
    begin
      a = {`BTI_ACCESS_LO_BANK, f};
    end
    else
    begin
      a = {`BTI_ACCESS_HI_BANK, f};
    end
    return a;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode of the presented word

  logic                   word_match;
  logic [2:0]             word_bit;
  logic                   word_bank_flag;
  logic [`BTI_DATA_W-1:0] word_file;
  logic                   accept;
  bti_phase_t             next_phase;

  assign word_match     = bti_is_invert(instr_word);
  assign word_bit       = instr_word[`BTI_BIT_HI:`BTI_BIT_LO];
  assign word_bank_flag = instr_word[`BTI_BANK_FLAG_POS];
  assign word_file      = instr_word[`BTI_FILE_HI:`BTI_FILE_LO];

  // words are only taken in the decode phase, any other time they are ignored
  assign accept      = ce && instr_valid && word_match && (q_phase == BTI_Q1);
  assign instr_taken = accept;

  ////////////////////////////////////////////////////////////////////////
  // quarter phase sequencer

  always_comb
  begin
    unique case (q_phase)
      BTI_Q1:
      begin
        next_phase = BTI_Q2;
      end
      BTI_Q2:
      begin
        next_phase = BTI_Q3;
      end
      BTI_Q3:
      begin
        next_phase = BTI_Q4;
      end
      BTI_Q4:
      begin
        next_phase = BTI_Q1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q_phase <= BTI_Q1;
    end
    else if (ce)
    begin
      q_phase <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // execution tracking: busy from decode to write back, three cycles (Q2 to Q4)

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      exec_busy <= 1'b0;
    end
    else if (ce)
    begin
      if (accept)
      begin
        exec_busy <= 1'b1;
      end
      else if (q_phase == BTI_Q4)
      begin
        exec_busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operand capture in decode

  logic [2:0] bit_sel;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_sel  <= `BTI_BIT_RST;
      mem_addr <= `BTI_ADDR_RST;
    end
    else if (ce && accept)
    begin
      bit_sel  <= word_bit;
      // bank select sampled once here, so a later change cannot split the access
      mem_addr <= bti_form_addr(word_bank_flag, bank_select_reg, word_file);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read of the target byte in Q2

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_rd_en <= 1'b0;
    end
    else if (ce)
    begin
      mem_rd_en <= accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // process stage in Q3: read data arrives here, flipped value ready for Q4

  logic flip_load;

  assign flip_load = exec_busy && (q_phase == BTI_Q3);

  bti_bit_flip u_flip
  (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .load    (flip_load),
    .bit_sel (bit_sel),
    .rdata   (mem_rdata),
    .wdata   (mem_wdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // write back in Q4, the final phase

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_wr_en <= 1'b0;
      exec_done <= 1'b0;
    end
    else if (ce)
    begin
      mem_wr_en <= flip_load;
      exec_done <= flip_load;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags: never written, even when the result byte is zero

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_wr_en <= 1'b0;
    end
    else if (ce)
    begin
      status_wr_en <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* design/bti_map.svh */
// bti_map.svh: offsets, field positions, reset values and timing counts
// for the bit-invert execution block.
// assumes: included by bare name from the package and the design modules.
`ifndef BTI_MAP_SVH
`define BTI_MAP_SVH

// instruction word layout
`define BTI_OPCODE          4'h7
`define BTI_OPC_HI          15
`define BTI_OPC_LO          12
`define BTI_BIT_HI          11
`define BTI_BIT_LO          9
`define BTI_BANK_FLAG_POS   8
`define BTI_FILE_HI         7
`define BTI_FILE_LO         0

// access bank mapping: lower half sits in bank 0, upper half in the top bank
`define BTI_ACCESS_SPLIT    8'h80
`define BTI_ACCESS_LO_BANK  4'h0
`define BTI_ACCESS_HI_BANK  4'hF

// widths
`define BTI_WORD_W          16
`define BTI_DATA_W          8
`define BTI_BANK_W          4
`define BTI_ADDR_W          12

// reset values
`define BTI_ADDR_RST        12'h000
`define BTI_DATA_RST        8'h00
`define BTI_BIT_RST         3'h0

// one instruction cycle is four clocks, one per quarter phase
`define BTI_CLK_PER_ICYC    4

`endif

/* design/bti_pkg.sv */
// bti_pkg: types and shared arithmetic for the bit-invert execution block.
// assumes: bti_map.svh is on the include path.
`include "bti_map.svh"

package bti_pkg;

  // quarter phases of one instruction cycle
  typedef enum logic [1:0]
  {
    BTI_Q1,
    BTI_Q2,
    BTI_Q3,
    BTI_Q4
  } bti_phase_t;

  typedef logic [`BTI_DATA_W-1:0] bti_byte_t;
  typedef logic [`BTI_ADDR_W-1:0] bti_addr_t;

  // one-hot mask for the selected bit
  function automatic bti_byte_t bti_bit_mask(input logic [2:0] bit_sel);
    bti_byte_t m;
    m = `BTI_DATA_RST;
    m[bit_sel] = 1'b1;
    return m;
  endfunction

endpackage

/* dv/bti_exec_monitor.sv */
// bti_exec_monitor: assertions on the ports of bti_exec.
// assumes: ce only low while no instruction is in flight; bound to every bti_exec.
`timescale 1ns/1ps
`include "bti_map.svh"
`default_nettype none

module bti_exec_monitor
  import bti_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [3:0]  bank_select_reg,
  input wire logic [7:0]  mem_rdata,
  input wire bti_phase_t  q_phase,
  input wire logic        instr_taken,
  input wire logic        exec_busy,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_rd_en,
  input wire logic        mem_wr_en,
  input wire logic [7:0]  mem_wdata,
  input wire logic        exec_done,
  input wire logic        status_wr_en
);
  ////////////////////////////////////////
  // bit number kept past Q1, the word may change after it
  logic [2:0] bsel;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bsel <= 3'h0;
    else if (instr_taken)
      bsel <= instr_word[11:9];
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////
  opcode_match_a: assert property (
    instr_taken == (q_phase == BTI_Q1 && ce && instr_valid && instr_word[15:12] == 4'h7))
    else $error("take does not follow opcode and phase");
  bit_flip_a: assert property (
    mem_wr_en |-> mem_wdata == ($past(mem_rdata) ^ (8'h01 << bsel)))
    else $error("written byte is not read byte with one bit inverted");
  access_bank_a: assert property (
    instr_taken && !instr_word[8] |=>
      mem_addr == {($past(instr_word[7]) ? 4'hF : 4'h0), $past(instr_word[7:0])})
    else $error("access bank address wrong");
  banked_addr_a: assert property (
    instr_taken && instr_word[8] |=> mem_addr == {$past(bank_select_reg), $past(instr_word[7:0])})
    else $error("banked address wrong");
  no_status_a: assert property (!status_wr_en)
    else $error("status flags written");
  read_phase_a: assert property (
    instr_taken |=> (mem_rd_en && exec_busy) ##1 (!mem_rd_en && exec_busy) [*2] ##1 !exec_busy)
    else $error("read or busy timing wrong");
  freeze_state_a: assert property (
    !ce |=> $stable(q_phase) && $stable(mem_addr) && $stable(exec_busy))
    else $error("state moved while clock enable low");
  write_phase_a: assert property (
    instr_taken |-> ##3 mem_wr_en && exec_done && q_phase == BTI_Q4)
    else $error("write back not in last phase");

  cover property (instr_taken && !instr_word[8]);
  cover property (instr_taken && instr_word[8]);
  cover property (mem_wr_en ##1 instr_taken);
  cover property (!ce && instr_valid);
endmodule

bind bti_exec bti_exec_monitor bti_exec_monitor_i (.clk(clk), .rst(rst), .ce(ce),
  .instr_valid(instr_valid), .instr_word(instr_word), .bank_select_reg(bank_select_reg),
  .mem_rdata(mem_rdata), .q_phase(q_phase), .instr_taken(instr_taken), .exec_busy(exec_busy),
  .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata),
  .exec_done(exec_done), .status_wr_en(status_wr_en));
`default_nettype wire

/* dv/tb.sv */
// tb: directed bench for bti_exec, plays core and data memory.
// assumes: read data is wanted in Q3, one clock after the read strobe.
`timescale 1ns/1ps
`include "bti_map.svh"
`default_nettype none

module tb;
  import bti_pkg::*;
  logic clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, ce = 1'b1;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_select_reg = 4'h0;
  logic [7:0] mem_rdata = 8'h00, mem_wdata;
  logic [11:0] mem_addr;
  logic instr_taken, exec_busy, mem_rd_en, mem_wr_en, exec_done, status_wr_en;
  bti_phase_t q_phase;
  int n_fail = 0, n_checks = 0;

  always #12.5 clk = ~clk;

  bti_exec bti_exec_i (.clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
    .instr_word(instr_word), .bank_select_reg(bank_select_reg), .mem_rdata(mem_rdata),
    .q_phase(q_phase), .instr_taken(instr_taken), .exec_busy(exec_busy), .mem_addr(mem_addr),
    .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata),
    .exec_done(exec_done), .status_wr_en(status_wr_en));

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // bounded wait for Q1, called and returning at a falling edge
  task automatic to_q1;
    int k;
    k = 0;
    while (q_phase !== BTI_Q1 && k < 8)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 8)
    begin
      n_fail++;
      end_of_test();
    end
  endtask

  // one instruction, four quarter phases, checked at each
  task automatic op(input logic [15:0] w, input logic [3:0] b, input logic [7:0] rd,
                    input logic [11:0] ea);
    to_q1();
    instr_word = w;
    instr_valid = 1'b1;
    bank_select_reg = b;
    #1 chk("taken", instr_taken, 1'b1);
    @(negedge clk);
    instr_valid = 1'b0;
    bank_select_reg = ~b;
    chk("rd_busy", {mem_rd_en, exec_busy}, 2'b11);
    chk("addr", mem_addr, ea);
    @(negedge clk);
    mem_rdata = rd;
    chk("wr_early", mem_wr_en, 1'b0);
    @(negedge clk);
    mem_rdata = ~rd;
    chk("wr_en", {mem_wr_en, exec_done}, 2'b11);
    chk("phase", q_phase, BTI_Q4);
    chk("wdata", mem_wdata, rd ^ (8'h01 << w[11:9]));
    chk("status", status_wr_en, 1'b0);
    @(negedge clk);
    chk("idle", {mem_wr_en, exec_done, exec_busy}, 3'b000);
  endtask

  ////////////////////////////////////////
  task automatic sc_access;
    op({4'h7, 3'h3, 1'b0, 8'h22}, 4'h5, 8'hF0, 12'h022);
    op({4'h7, 3'h0, 1'b0, 8'hFF}, 4'h5, 8'h00, 12'hFFF);
  endtask

  task automatic sc_banked;
    op({4'h7, 3'h4, 1'b1, 8'h80}, 4'hA, 8'h75, 12'hA80);
    op({4'h7, 3'h7, 1'b1, 8'h00}, 4'h0, 8'hFF, 12'h000);
  endtask

  // with ce low nothing moves and no word is taken
  task automatic sc_freeze;
    to_q1();
    ce = 1'b0;
    instr_word = {4'h7, 3'h2, 1'b0, 8'h90};
    instr_valid = 1'b1;
    #1 chk("frz_take", instr_taken, 1'b0);
    repeat (3) @(negedge clk);
    chk("frz_state", {q_phase, mem_rd_en, exec_busy}, {BTI_Q1, 2'b00});
    ce = 1'b1;
    op({4'h7, 3'h2, 1'b0, 8'h90}, 4'h6, 8'h04, 12'hF90);
  endtask

  // reset in mid instruction drops the strobes and restarts at Q1
  task automatic sc_reset;
    to_q1();
    instr_word = {4'h7, 3'h1, 1'b1, 8'h10};
    instr_valid = 1'b1;
    bank_select_reg = 4'h2;
    @(negedge clk);
    instr_valid = 1'b0;
    rst = 1'b1;
    #1 chk("rst_out", {mem_rd_en, exec_busy, mem_addr}, 14'h0000);
    chk("rst_phase", q_phase, BTI_Q1);
    repeat (2) @(negedge clk);
    rst = 1'b0;
    op({4'h7, 3'h1, 1'b1, 8'h10}, 4'h2, 8'h3C, 12'h210);
  endtask

  // back to back through every bit number
  task automatic sc_all_bits;
    for (int i = 0; i < 8; i++)
      op({4'h7, i[2:0], 1'b1, 8'h5C}, 4'h3, 8'hA5, 12'h35C);
  endtask

  task automatic sc_refuse;
    to_q1();
    instr_word = 16'h6122;
    instr_valid = 1'b1;
    #1 chk("bad_op", instr_taken, 1'b0);
    @(negedge clk);
    instr_word = 16'h7122;
    #1 chk("late", instr_taken, 1'b0);
    chk("no_rd", {mem_rd_en, exec_busy}, 2'b00);
    @(negedge clk);
    instr_valid = 1'b0;
  endtask

  ////////////////////////////////////////
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    sc_access();
    sc_banked();
    sc_all_bits();
    sc_freeze();
    sc_reset();
    sc_refuse();
    repeat (4) @(negedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
